// *** hdl/amp_ctrl_defs.svh ***
`ifndef AMP_CTRL_DEFS_SVH
`define AMP_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Link address and framing
// ----------------------------------------------------------------
`define ADDR_BYTE 8'hD8
`define DIR_BIT 0
`define BITS_PER_BYTE 4'h8
`define DIAG_BYTES 2'h3
`define SYNC_STAGES 2

// ----------------------------------------------------------------
// Control byte one fields
// ----------------------------------------------------------------
`define C1_DIAG_REPEAT 7
`define C1_DIAG_EN 6
`define C1_OFFSET_EN 5
`define C1_FRONT_GAIN 4
`define C1_REAR_GAIN 3
`define C1_FRONT_UNMUTE 2
`define C1_REAR_UNMUTE 1
`define C1_CLIP_THRESH 0
`define CTRL1_RESET 8'h00

// ----------------------------------------------------------------
// Control byte two fields
// ----------------------------------------------------------------
`define C2_CUR_THRESH 7
`define C2_FAST_MUTE 6
`define C2_DET_SELECT 5
`define C2_RUN 4
`define C2_LINE_MODE 3
`define C2_CUR_EN 2
`define C2_FRONT_LOWQ 1
`define C2_REAR_LOWQ 0
`define CTRL2_RESET 8'h00

// ----------------------------------------------------------------
// Diagnostic byte fields
// ----------------------------------------------------------------
`define D_TOP 7
`define D_NEXT 6
`define D_CURRENT 5
`define D_PERMANENT 4
`define D_SHORT_LOAD 3
`define D_OPEN_OFFSET 2
`define D_SHORT_VCC 1
`define D_SHORT_GND 0

`endif

// *** hdl/amp_ctrl_pkg.sv ***
package amp_ctrl_pkg;

    // Link sequencer states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_BYTE = 3'h2,
        ST_WR_ACK = 3'h6,
        ST_RD_BYTE = 3'h7,
        ST_RD_ACK = 3'h5
    } link_state_e;

    typedef logic [7:0] byte_t;
    typedef logic [5:0] chan_field_t;

endpackage

// *** hdl/amp_i2c_control_diagnostics.sv ***
// Summary of operation
// - Answer only address bytes D8 (write) and D9 (read) hex
// - Direction bit: 0 writes, 1 reads
// - Read returns four diagnostic bytes, channel one first
// - Byte one D6 diag enable, D7 repeat
// - Byte one D5 enables offset detection
// - Byte one D4/D3 gain, 1 means 12dB
// - D2/D1 unmute pairs, D0 clip threshold
// - Byte two D7 selects 300 mA threshold
// - Byte two D6 turns fast mute on
// - Byte two D5 picks shared detector source
// - Byte two D4 low holds standby
// - Byte two D3 selects line-driver diagnostics
// - Byte two D2 enables current detection
// - Byte two D1/D0 low quiescent modes
// - Channel one D7 shows thermal warning
// - Channel one D6 shows diagnosis finished
// - D5 flags open load by current
// - D4 tells turn-on from permanent diagnosis
// - D3 short load, D2 open/offset
// - D1 short to supply, D0 ground
// - Ground plus supply short reported once only in permanent diagnosis
// - Offset indication added in permanent diagnosis
// - Bytes two to four repeat channel fields
// - Byte three mirrors standby and diag enable
// - Current flag valid only when enabled
`timescale 1ns/1ps
`include "amp_ctrl_defs.svh"

module amp_i2c_control_diagnostics
    import amp_ctrl_pkg::*;
(
    input wire logic core_clk, // 50 MHz system clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic scl_in, // Serial clock pin level
    input wire logic sda_in, // Serial data pin level
    output logic sda_out, // Serial data drive value
    output logic sda_oe_n, // Low while pulling data low
    input wire logic thermal_warn, // Die near shutdown
    input wire logic diag_done, // Diagnostic cycle finished
    input wire logic clip_det, // Clip comparator
    input wire logic offset_det, // Offset comparator
    input wire logic [3:0] perm_diag, // Permanent diagnosis active
    input wire logic [3:0] cur_open, // Peak current below limit
    input wire logic [3:0] short_load, // Output to output short
    input wire logic [3:0] open_load, // Turn-on open load
    input wire logic [3:0] out_offset, // Output offset seen
    input wire logic [3:0] short_vcc, // Output shorted to supply
    input wire logic [3:0] short_gnd, // Output shorted to ground
    output logic diag_repeat, // Turn-on diag repeat timing
    output logic diag_cycle_en, // Turn-on diag enabled
    output logic offset_det_en, // Offset detection enabled
    output logic front_gain_low, // Front gain 12dB
    output logic rear_gain_low, // Rear gain 12dB
    output logic front_unmute, // Front pair unmuted
    output logic rear_unmute, // Rear pair unmuted
    output logic clip_thresh_high, // Clip threshold 10%
    output logic cur_thresh_low, // Current threshold 300 mA
    output logic fast_mute, // Fast mute on
    output logic det_sel_offset, // Shared output shows offset
    output logic amp_run, // Out of standby
    output logic line_mode_diag, // Line-driver diagnostics
    output logic cur_det_en, // Current detection enabled
    output logic front_low_iq, // Front low quiescent mode
    output logic rear_low_iq, // Rear low quiescent mode
    output logic shared_detector_output // Clip or offset indication
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int SW = 34;
    logic [SW-1:0] async_in;
    logic [SW-1:0] meta_reg;
    logic [SW-1:0] sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;

    assign async_in = {scl_in, sda_in, thermal_warn, diag_done, clip_det,
        offset_det, perm_diag, cur_open, short_load, open_load, out_offset,
        short_vcc, short_gnd};

    // Two stages on every pin; only the second stage is read.
    // Bus lines clear to their idle high so no false edge follows reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= {2'h3, 32'h0};
            sync_reg <= {2'h3, 32'h0};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    wire scl_s = sync_reg[33];
    wire sda_s = sync_reg[32];
    wire therm_s = sync_reg[31];
    wire done_s = sync_reg[30];
    wire clip_s = sync_reg[29];
    wire offs_s = sync_reg[28];
    wire [3:0] perm_s = sync_reg[27:24];
    wire [3:0] cur_s = sync_reg[23:20];
    wire [3:0] sload_s = sync_reg[19:16];
    wire [3:0] open_s = sync_reg[15:12];
    wire [3:0] offc_s = sync_reg[11:8];
    wire [3:0] vcc_s = sync_reg[7:4];
    wire [3:0] gnd_s = sync_reg[3:0];

    // Delayed copies for edge finding on the synchronised lines
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_cond = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
    wire stop_cond = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

    // ----------------------------------------------------------------
    // Control bytes
    // ----------------------------------------------------------------
    byte_t ctrl1_reg;
    byte_t ctrl2_reg;

    assign diag_repeat = ctrl1_reg[`C1_DIAG_REPEAT];
    assign diag_cycle_en = ctrl1_reg[`C1_DIAG_EN];
    assign offset_det_en = ctrl1_reg[`C1_OFFSET_EN];
    assign front_gain_low = ctrl1_reg[`C1_FRONT_GAIN];
    assign rear_gain_low = ctrl1_reg[`C1_REAR_GAIN];
    assign front_unmute = ctrl1_reg[`C1_FRONT_UNMUTE];
    assign rear_unmute = ctrl1_reg[`C1_REAR_UNMUTE];
    assign clip_thresh_high = ctrl1_reg[`C1_CLIP_THRESH];
    assign cur_thresh_low = ctrl2_reg[`C2_CUR_THRESH];
    assign fast_mute = ctrl2_reg[`C2_FAST_MUTE];
    assign det_sel_offset = ctrl2_reg[`C2_DET_SELECT];
    assign amp_run = ctrl2_reg[`C2_RUN];
    assign line_mode_diag = ctrl2_reg[`C2_LINE_MODE];
    assign cur_det_en = ctrl2_reg[`C2_CUR_EN];
    assign front_low_iq = ctrl2_reg[`C2_FRONT_LOWQ];
    assign rear_low_iq = ctrl2_reg[`C2_REAR_LOWQ];

    // Shared detector pin, registered so the pin never glitches
    logic det_out_reg;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            det_out_reg <= 1'b0;
        end else begin
            det_out_reg <= det_sel_offset ? offs_s : clip_s;
        end
    end
    assign shared_detector_output = det_out_reg;

    // ----------------------------------------------------------------
    // Diagnostic bytes
    // ----------------------------------------------------------------
    // Builds the six per-channel fields; shared by all four channels
    function automatic chan_field_t chan_field(
        input logic perm, input logic cur, input logic sload,
        input logic open, input logic offs, input logic vcc,
        input logic gnd, input logic cur_en, input logic offs_en,
        input logic seen
    );
        chan_field_t f;
        logic both;
        f = '0;
        both = perm & gnd & vcc;
        f[`D_CURRENT] = cur & cur_en;
        f[`D_PERMANENT] = perm;
        f[`D_SHORT_LOAD] = sload;
        // Turn-on reports open load; permanent adds offset when enabled
        f[`D_OPEN_OFFSET] = perm ? (offs & offs_en) : open;
        // In permanent diagnosis a ground plus supply short shows once as ground, then vanishes
        f[`D_SHORT_VCC] = vcc & ~both;
        f[`D_SHORT_GND] = both ? ~seen : gnd;
        return f;
    endfunction

    logic [3:0] seen_reg;
    logic [3:0] combined;
    chan_field_t fields [4];
    byte_t diag_bytes [4];

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            assign combined[ch] = perm_s[ch] & gnd_s[ch] & vcc_s[ch];
            assign fields[ch] = chan_field(perm_s[ch], cur_s[ch],
                sload_s[ch], open_s[ch], offc_s[ch], vcc_s[ch], gnd_s[ch],
                cur_det_en, offset_det_en, seen_reg[ch]);
        end
    endgenerate

    // Top two bits differ per byte; the fourth byte reads zero there
    assign diag_bytes[0] = {therm_s, done_s & diag_cycle_en,
        fields[0]};
    assign diag_bytes[1] = {offset_det_en, cur_det_en, fields[1]};
    assign diag_bytes[2] = {amp_run, diag_cycle_en, fields[2]};
    assign diag_bytes[3] = {2'h0, fields[3]};

    // ----------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------
    link_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    byte_t shift_reg;
    byte_t tx_reg;
    logic [1:0] rd_idx_reg;
    logic [1:0] wr_idx_reg;
    logic nack_reg;
    logic drive_reg;

    wire byte_done = (bit_cnt_reg == `BITS_PER_BYTE);
    wire addr_hit = (shift_reg[7:1] == 7'(`ADDR_BYTE >> 1));
    wire dir_read = shift_reg[`DIR_BIT];
    wire wr_accept = (wr_idx_reg != 2'h2);
    wire byte_load = scl_fall & ((state_reg == ST_ADDR_ACK & dir_read)
        | (state_reg == ST_RD_ACK & ~nack_reg));
    wire [1:0] load_idx = (state_reg == ST_ADDR_ACK) ? 2'h0 : rd_idx_reg;

    // Main sequencer; start and stop override any state
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            rd_idx_reg <= 2'h0;
            wr_idx_reg <= 2'h0;
            nack_reg <= 1'b0;
            drive_reg <= 1'b0;
            ctrl1_reg <= `CTRL1_RESET;
            ctrl2_reg <= `CTRL2_RESET;
        end else if (start_cond) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            drive_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        // Foreign address: stay silent until next start
                        state_reg <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                        drive_reg <= addr_hit;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        wr_idx_reg <= 2'h0;
                        if (dir_read) begin
                            state_reg <= ST_RD_BYTE;
                            drive_reg <= ~diag_bytes[load_idx][7];
                            tx_reg <= {diag_bytes[load_idx][6:0], 1'b0};
                            rd_idx_reg <= load_idx + 2'h1;
                        end else begin
                            state_reg <= ST_WR_BYTE;
                            drive_reg <= 1'b0;
                        end
                    end
                end
                ST_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        // Extra bytes past the second are refused
                        state_reg <= ST_WR_ACK;
                        drive_reg <= wr_accept;
                        if (wr_idx_reg == 2'h0) begin
                            ctrl1_reg <= shift_reg;
                        end else if (wr_idx_reg == 2'h1) begin
                            ctrl2_reg <= shift_reg;
                        end
                        if (wr_accept) begin
                            wr_idx_reg <= wr_idx_reg + 2'h1;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        state_reg <= ST_WR_BYTE;
                        bit_cnt_reg <= 4'h0;
                        drive_reg <= 1'b0;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        state_reg <= ST_RD_ACK;
                        drive_reg <= 1'b0;
                    end else if (scl_fall) begin
                        drive_reg <= ~tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        nack_reg <= sda_s;
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (nack_reg) begin
                            state_reg <= ST_IDLE;
                            drive_reg <= 1'b0;
                        end else begin
                            // After the fourth byte the order wraps
                            state_reg <= ST_RD_BYTE;
                            drive_reg <= ~diag_bytes[load_idx][7];
                            tx_reg <= {diag_bytes[load_idx][6:0], 1'b0};
                            rd_idx_reg <= load_idx + 2'h1;
                        end
                    end
                end
                default: begin
                    drive_reg <= 1'b0;
                end
            endcase
        end
    end

    // Once-only memory: marked when a byte carrying it is sent,
    // forgotten when the double short goes away
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!combined[i]) begin
                    seen_reg[i] <= 1'b0;
                end else if (byte_load && load_idx == i[1:0]) begin
                    seen_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Open-drain pin: value always low, enable carries the data
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= ~drive_reg;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_addr_miss_idle: assert property (
        (state_reg == ST_ADDR && !start_cond && !stop_cond && scl_fall
            && byte_done && !addr_hit) |=> ##1 sda_oe_n && state_reg == ST_IDLE)
        else $error("foreign address was acknowledged");

    a_dir_write_path: assert property (
        (state_reg == ST_ADDR_ACK && !start_cond && !stop_cond && scl_fall
            && !dir_read) |=> state_reg == ST_WR_BYTE ##1 sda_oe_n)
        else $error("write direction did not release for data");

    a_read_first_byte: assert property (
        (state_reg == ST_ADDR_ACK && !start_cond && !stop_cond && scl_fall
            && dir_read) |=> ##1 sda_oe_n == $past(diag_bytes[0][7], 2)
            && rd_idx_reg == 2'h1)
        else $error("read did not start with channel one byte");

    a_ctrl1_store: assert property (
        (state_reg == ST_WR_BYTE && !start_cond && !stop_cond && scl_fall
            && byte_done && wr_idx_reg == 2'h0)
            |=> ctrl1_reg == $past(shift_reg) && wr_idx_reg == 2'h1)
        else $error("first control byte not stored");

    a_ctrl2_store: assert property (
        (state_reg == ST_WR_BYTE && !start_cond && !stop_cond && scl_fall
            && byte_done && wr_idx_reg == 2'h1)
            |=> ctrl2_reg == $past(shift_reg) && cur_thresh_low
            == $past(shift_reg[`C2_CUR_THRESH]))
        else $error("second control byte not stored");

    a_extra_byte_nack: assert property (
        (state_reg == ST_WR_BYTE && !start_cond && !stop_cond && scl_fall
            && byte_done && wr_idx_reg == 2'h2) |=> ##1 sda_oe_n
            && $stable(ctrl1_reg) && $stable(ctrl2_reg))
        else $error("third write byte was accepted");

    a_detector_route: assert property (
        $stable(ctrl2_reg) && $stable(clip_s) && $stable(offs_s)
            |=> shared_detector_output
            == $past(det_sel_offset ? offs_s : clip_s))
        else $error("shared detector shows wrong source");

    a_thermal_flag: assert property (
        diag_bytes[0][`D_TOP] == therm_s)
        else $error("thermal warning not reported");

    a_standby_mirror: assert property (
        diag_bytes[2][`D_TOP] == ctrl2_reg[`C2_RUN]
            && diag_bytes[2][`D_NEXT] == ctrl1_reg[`C1_DIAG_EN])
        else $error("third byte does not mirror controls");

    a_current_mask: assert property (
        !ctrl2_reg[`C2_CUR_EN] |-> diag_bytes[0][`D_CURRENT] == 1'b0
            && diag_bytes[3][`D_CURRENT] == 1'b0)
        else $error("current flag shown while disabled");

    a_double_once: assert property (
        (combined[0] && seen_reg[0]) |-> diag_bytes[0][1:0] == 2'h0)
        else $error("double short reported more than once");

endmodule // amp_i2c_control_diagnostics

// *** tb/i2c_master_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Bus master model, scl stands high between frames
// ------------------------------------------------
module i2c_master_model
    import amp_ctrl_pkg::*;
#(
    parameter int HALF = 8 // Core cycles per scl half
) (
    input wire logic core_clk, // Bench clock
    input wire logic sda, // Resolved data wire
    output logic scl, // Serial clock
    output logic sda_rel // High releases data wire
);
    // Halves are kept wide so the sync delay never eats a phase
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Start, or repeated start from a low clock
    task automatic start();
        sda_rel <= 1'b1;
        wt(HALF);
        scl <= 1'b1;
        wt(HALF);
        sda_rel <= 1'b0;
        wt(HALF);
        scl <= 1'b0;
        wt(1);
    endtask
    task automatic stop();
        sda_rel <= 1'b0;
        wt(HALF);
        scl <= 1'b1;
        wt(HALF);
        sda_rel <= 1'b1;
        wt(HALF);
    endtask
    // Data changes only while scl is low
    task automatic xbit(input logic b, output logic r);
        sda_rel <= b;
        wt(HALF);
        scl <= 1'b1;
        wt(HALF / 2);
        r = sda;
        wt(HALF / 2);
        scl <= 1'b0;
        wt(2);
    endtask
    // Eight bits then the ack slot; last high means release
    task automatic xbyte(input byte_t d, input logic last,
                         output byte_t r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r[i]);
        end
        xbit(last, a);
        ack = ~a;
    endtask
endmodule // i2c_master_model

// *** tb/amp_i2c_control_diagnostics_bench.sv ***
`timescale 1ns/1ps
`include "amp_ctrl_defs.svh"
module amp_i2c_control_diagnostics_bench
    import amp_ctrl_pkg::*;
;
    logic core_clk, sys_rst, thermal_warn, diag_done, clip_det;
    logic offset_det, sda_out, sda_oe_n, scl, sda_rel, shared_out;
    logic [3:0] perm_diag, cur_open, short_load, open_load;
    logic [3:0] out_offset, short_vcc, short_gnd, seen;
    byte_t ctrl1, ctrl2, c1, c2;
    int num_errors, checks_done;
    wire sda = sda_rel & (sda_oe_n | sda_out); // Pulled up
    i2c_master_model #(.HALF(8)) m (.core_clk(core_clk), .sda(sda),
        .scl(scl), .sda_rel(sda_rel));
    amp_i2c_control_diagnostics amp_i2c_control_diagnostics_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .thermal_warn(thermal_warn), .diag_done(diag_done),
        .clip_det(clip_det), .offset_det(offset_det),
        .perm_diag(perm_diag), .cur_open(cur_open),
        .short_load(short_load), .open_load(open_load),
        .out_offset(out_offset), .short_vcc(short_vcc),
        .short_gnd(short_gnd), .diag_repeat(ctrl1[7]),
        .diag_cycle_en(ctrl1[6]), .offset_det_en(ctrl1[5]),
        .front_gain_low(ctrl1[4]), .rear_gain_low(ctrl1[3]),
        .front_unmute(ctrl1[2]), .rear_unmute(ctrl1[1]),
        .clip_thresh_high(ctrl1[0]), .cur_thresh_low(ctrl2[7]),
        .fast_mute(ctrl2[6]), .det_sel_offset(ctrl2[5]),
        .amp_run(ctrl2[4]), .line_mode_diag(ctrl2[3]),
        .cur_det_en(ctrl2[2]), .front_low_iq(ctrl2[1]),
        .rear_low_iq(ctrl2[0]), .shared_detector_output(shared_out));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input string what, input byte_t e, input byte_t g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // Expected diagnostic byte from the live fault levels
    function automatic byte_t exp_diag(input int k);
        logic both;
        logic [1:0] top;
        both = perm_diag[k] & short_vcc[k] & short_gnd[k];
        case (k)
            0: top = {thermal_warn, diag_done & c1[6]};
            1: top = {c1[5], c2[2]};
            2: top = {c2[4], c1[6]};
            default: top = 2'b00;
        endcase
        return {top, cur_open[k] & c2[2], perm_diag[k], short_load[k],
            perm_diag[k] ? out_offset[k] & c1[5] : open_load[k],
            short_vcc[k] & ~both, both ? ~seen[k] : short_gnd[k]};
    endfunction
    task automatic wr(input byte_t a, input byte_t b);
        byte_t r;
        logic k;
        m.start();
        m.xbyte(`ADDR_BYTE, 1'b1, r, k);
        check("write address ack", 8'h01, {7'h0, k});
        m.xbyte(a, 1'b1, r, k);
        check("first byte ack", 8'h01, {7'h0, k});
        m.xbyte(b, 1'b1, r, k);
        check("second byte ack", 8'h01, {7'h0, k});
        m.xbyte(8'h00, 1'b1, r, k);
        check("extra byte ack", 8'h00, {7'h0, k});
        m.stop();
        c1 = a;
        c2 = b;
        check("control one", c1, ctrl1);
        check("control two", c2, ctrl2);
        clip_det <= 1'b1;
        offset_det <= 1'b0;
        m.wt(6);
        check("detector out", {7'h0, ~c2[5]}, {7'h0, shared_out});
    endtask
    task automatic rd();
        byte_t r;
        logic k;
        m.start();
        m.xbyte(`ADDR_BYTE | 8'h01, 1'b1, r, k);
        check("read address ack", 8'h01, {7'h0, k});
        for (int i = 0; i < 4; i++) begin
            m.xbyte(8'hFF, i == 3, r, k);
            check("diag byte", exp_diag(i), r);
            seen[i] = seen[i] | (perm_diag[i] & short_vcc[i]
                & short_gnd[i]);
        end
        m.stop();
    endtask
    task automatic test_writes();
        check("release at rest", 8'h01, {7'h0, sda_oe_n});
        check("control reset", 8'h00, ctrl1 | ctrl2);
        wr(8'hA5, 8'h5A);
        wr(8'h5A, 8'hA5);
        $display("test writes done");
    endtask
    // Foreign address must be ignored with controls untouched
    task automatic test_bad_addr();
        byte_t r;
        logic k;
        m.start();
        m.xbyte(8'hDA, 1'b1, r, k);
        check("foreign address ack", 8'h00, {7'h0, k});
        m.xbyte(8'hFF, 1'b1, r, k);
        m.stop();
        check("control one kept", c1, ctrl1);
        check("control two kept", c2, ctrl2);
        $display("test bad address done");
    endtask
    task automatic test_reads();
        thermal_warn <= 1'b1;
        diag_done <= 1'b1;
        cur_open <= 4'h5;
        perm_diag <= 4'h3;
        short_load <= 4'h8;
        open_load <= 4'hF;
        out_offset <= 4'h6;
        short_vcc <= 4'h4;
        short_gnd <= 4'h8;
        m.wt(4);
        rd();
        wr(8'h25, 8'h10);
        rd();
        $display("test reads done");
    endtask
    // Ground and supply short together shows once only
    task automatic test_double();
        perm_diag <= 4'h1;
        short_gnd <= 4'h1;
        short_vcc <= 4'h1;
        out_offset <= 4'h1;
        m.wt(4);
        seen = 4'h0;
        rd();
        rd();
        $display("test double short done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {thermal_warn, diag_done, clip_det, offset_det} = 4'h0;
        {perm_diag, cur_open, short_load, open_load} = 16'h0;
        {out_offset, short_vcc, short_gnd, seen} = 16'h0;
        {c1, c2} = 16'h0;
        sys_rst = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        m.wt(4);
        test_writes();
        test_bad_addr();
        test_reads();
        test_double();
        finish_test();
    end
    // Watchdog, several times the expected run
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end
endmodule // amp_i2c_control_diagnostics_bench
